// [shared/swcfg_map.svh]
// register offsets, field positions and reset values of the switch current config bank
`ifndef SWCFG_MAP_SVH
`define SWCFG_MAP_SVH

// register indices; the byte address is four times the index
`define SWCFG_SELECT_IDX      8'h1C
`define SWCFG_LEVEL_IDX       8'h1D

// extra registers, byte addresses
`define SWCFG_ENABLE_ADDR     12'h100
`define SWCFG_CTRL_ADDR       12'h104
`define SWCFG_STATUS_ADDR     12'h108

// widths
`define SWCFG_REG_W           24
`define SWCFG_DIR_W           10
`define SWCFG_CHAN_N          12
`define SWCFG_CODE_W          3

// control register fields
`define SWCFG_CTRL_CONT_BIT   0
`define SWCFG_CTRL_DIS_SRC    1
`define SWCFG_CTRL_DIS_SNK    2
`define SWCFG_CTRL_W          3

// reset values
`define SWCFG_SELECT_RST      10'h000
`define SWCFG_LEVEL_RST       24'h000000
`define SWCFG_ENABLE_RST      12'h000
`define SWCFG_CTRL_RST        3'h0

// AHB encodings
`define SWCFG_HSIZE_WORD      3'h2
`define SWCFG_ADDR_W          12

`endif

// [shared/swcfg_pkg.sv]
// types shared by the switch current config bank
package swcfg_pkg;

   typedef enum logic [2:0] {
      SWCFG_OFF  = 3'b000,
      SWCFG_MA1  = 3'b001,
      SWCFG_MA2  = 3'b010,
      SWCFG_MA5  = 3'b011,
      SWCFG_MA10 = 3'b100,
      SWCFG_MA15 = 3'b101
   } swcfg_current_t;

   typedef enum logic [1:0] {
      SWCFG_BUS_IDLE  = 2'b00,
      SWCFG_BUS_WRITE = 2'b01,
      SWCFG_BUS_RWAIT = 2'b10,
      SWCFG_BUS_RDONE = 2'b11
   } swcfg_bus_state_t;

endpackage

// [shared/swcfg_chan_if.sv]
// per-channel signals between the register bank and the level decoder
`timescale 1ns/1ps
`default_nettype none

interface swcfg_chan_if;
   logic [2:0]                 code;
   logic                       sink;
   logic                       closed;
   logic                       enabled;
   logic                       continuous;
   logic                       dis_source;
   logic                       dis_sink;
   swcfg_pkg::swcfg_current_t  level;
   logic                       polled;

   modport cfg (
      output code,
      output sink,
      output closed,
      output enabled,
      output continuous,
      output dis_source,
      output dis_sink,
      input  level,
      input  polled
   );

   modport dec (
      input  code,
      input  sink,
      input  closed,
      input  enabled,
      input  continuous,
      input  dis_source,
      input  dis_sink,
      output level,
      output polled
   );
endinterface // swcfg_chan_if

`default_nettype wire

// [logic/swcfg_level_decode.sv]
// decodes one channel's level code into its effective wetting current
`timescale 1ns/1ps
`default_nettype none

module swcfg_level_decode (
   // channel configuration and result
   swcfg_chan_if.dec  port
);

   swcfg_pkg::swcfg_current_t  base;
   swcfg_pkg::swcfg_current_t  lvl;
   logic                       scale_dis;

   always_comb begin
      case (port.code)
         3'h0:    base = swcfg_pkg::SWCFG_OFF;
         3'h1:    base = swcfg_pkg::SWCFG_MA1;
         3'h2:    base = swcfg_pkg::SWCFG_MA2;
         3'h3:    base = swcfg_pkg::SWCFG_MA5;
         3'h4:    base = swcfg_pkg::SWCFG_MA10;
         default: base = swcfg_pkg::SWCFG_MA15;  // codes 5..7
      endcase
      // the group follows the channel's current direction
      scale_dis = port.sink ? port.dis_sink : port.dis_source;
      lvl = base;
      if (port.continuous && port.closed && !scale_dis &&
          (base == swcfg_pkg::SWCFG_MA10 || base == swcfg_pkg::SWCFG_MA15)) begin
         lvl = swcfg_pkg::SWCFG_MA2;
      end
      // a disabled channel is never wetted, whatever its code
      if (!port.enabled) begin
         lvl = swcfg_pkg::SWCFG_OFF;
      end
   end

   assign port.level  = lvl;
   assign port.polled = port.enabled;

endmodule // swcfg_level_decode

`default_nettype wire

// [logic/swcfg_regs.sv]
// switch input current configuration registers behind an AHB-Lite slave
//
// What this block does
// - select register at index 1Ch resets zero
// - select bits 23..10 read as zero
// - select bit n: 0 source, 1 sink
// - level register at index 1Dh resets zero
// - codes: off,1,2,5,10mA; 5..7 mean 15mA
// - upper fields: ch11, ch10, pair 8/9, 6/7
// - lower fields: ch5, ch4, pair 2/3, 0/1
// - continuous mode closure drops 10/15mA to 2mA
// - disabled channel skipped by polling
`timescale 1ns/1ps
`include "swcfg_map.svh"
`default_nettype none

module swcfg_regs #(
   parameter int CHAN_N = `SWCFG_CHAN_N
) (
   // clock and reset
   input  wire logic                       clock,
   input  wire logic                       rst,
   // AHB-Lite slave
   input  wire logic                       hsel,
   input  wire logic [31:0]                haddr,
   input  wire logic [1:0]                 htrans,
   input  wire logic                       hwrite,
   input  wire logic [2:0]                 hsize,
   input  wire logic                       hready,
   input  wire logic [31:0]                hwdata,
   output logic                            hreadyout,
   output logic [31:0]                     hrdata,
   output logic                            hresp,
   // switch closure pins, asynchronous
   input  wire logic [CHAN_N-1:0]          switch_closed,
   // per-channel results
   output logic [CHAN_N-1:0]               chan_sink,
   output logic [3*CHAN_N-1:0]             chan_level,
   output logic [CHAN_N-1:0]               chan_polled
);

   localparam logic [11:0] SELECT_ADDR = {2'b00, `SWCFG_SELECT_IDX, 2'b00};
   localparam logic [11:0] LEVEL_ADDR  = {2'b00, `SWCFG_LEVEL_IDX, 2'b00};

   // bus state
   swcfg_pkg::swcfg_bus_state_t  bus_reg;
   swcfg_pkg::swcfg_bus_state_t  bus_next;
   logic [`SWCFG_ADDR_W-1:0]     addr_reg;
   logic                         word_reg;
   logic [31:0]                  rdata_reg;
   logic [31:0]                  rdata_next;
   logic                         accept;

   // register contents
   logic [`SWCFG_DIR_W-1:0]      select_reg;
   logic [`SWCFG_REG_W-1:0]      level_reg;
   logic [CHAN_N-1:0]            enable_reg;
   logic [`SWCFG_CTRL_W-1:0]     ctrl_reg;

   // pin synchroniser
   logic [CHAN_N-1:0]            closed_meta_reg;
   logic [CHAN_N-1:0]            closed_sync_reg;

   // decoder results before the output flops
   wire logic [CHAN_N-1:0]       sink_comb;
   wire logic [3*CHAN_N-1:0]     level_comb;
   wire logic [CHAN_N-1:0]       polled_comb;

   logic                         wr_commit;

   // write decode of the captured address
   logic                         hit_select;
   logic                         hit_level;
   logic                         hit_enable;
   logic                         hit_ctrl;
   logic                         we_select;
   logic                         we_level;
   logic                         we_enable;
   logic                         we_ctrl;

   // -------------------------------------------------------------------
   // AHB-Lite slave
   // -------------------------------------------------------------------

   // reads take one wait state so that a write just before is visible
   assign hreadyout = (bus_reg != swcfg_pkg::SWCFG_BUS_RWAIT);
   // every transfer, refused ones included, answers OKAY
   assign hresp     = 1'b0;
   assign hrdata    = rdata_reg;

   assign accept    = hsel && hready && htrans[1];
   assign wr_commit = (bus_reg == swcfg_pkg::SWCFG_BUS_WRITE) && word_reg;

   // RDONE takes a new address at once, so back-to-back reads cost two cycles each
   always_comb begin
      bus_next = swcfg_pkg::SWCFG_BUS_IDLE;
      case (bus_reg)
         swcfg_pkg::SWCFG_BUS_RWAIT: begin
            bus_next = swcfg_pkg::SWCFG_BUS_RDONE;
         end
         swcfg_pkg::SWCFG_BUS_IDLE,
         swcfg_pkg::SWCFG_BUS_WRITE,
         swcfg_pkg::SWCFG_BUS_RDONE: begin
            if (accept) begin
               bus_next = hwrite ? swcfg_pkg::SWCFG_BUS_WRITE : swcfg_pkg::SWCFG_BUS_RWAIT;
            end
         end
         default: begin
            bus_next = swcfg_pkg::SWCFG_BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         bus_reg <= swcfg_pkg::SWCFG_BUS_IDLE;
      end else begin
         bus_reg <= bus_next;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         addr_reg <= 12'h000;
      end else if (accept && hreadyout) begin
         addr_reg <= haddr[`SWCFG_ADDR_W-1:0];
      end
   end

   // narrow or misaligned writes are refused whole rather than merged,
   // so no half-written level field ever reaches the current sources
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         word_reg <= 1'b0;
      end else if (accept && hreadyout) begin
         word_reg <= (hsize == `SWCFG_HSIZE_WORD) && (haddr[1:0] == 2'b00);
      end
   end

   // read mux; unmapped addresses read as zero
   always_comb begin
      rdata_next = 32'h00000000;
      case (addr_reg)
         SELECT_ADDR:        rdata_next = {22'h000000, select_reg};
         LEVEL_ADDR:         rdata_next = {8'h00, level_reg};
         `SWCFG_ENABLE_ADDR: rdata_next = {20'h00000, enable_reg};
         `SWCFG_CTRL_ADDR:   rdata_next = {29'h00000000, ctrl_reg};
         `SWCFG_STATUS_ADDR: rdata_next = {20'h00000, closed_sync_reg};
         default:            rdata_next = 32'h00000000;
      endcase
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rdata_reg <= 32'h00000000;
      end else if (bus_reg == swcfg_pkg::SWCFG_BUS_RWAIT) begin
         rdata_reg <= rdata_next;
      end
   end

   // -------------------------------------------------------------------
   // write decode
   // -------------------------------------------------------------------

   // the data phase uses the address captured in the address phase
   assign hit_select = (addr_reg == SELECT_ADDR);
   assign hit_level  = (addr_reg == LEVEL_ADDR);
   assign hit_enable = (addr_reg == `SWCFG_ENABLE_ADDR);
   assign hit_ctrl   = (addr_reg == `SWCFG_CTRL_ADDR);

   // unmapped, narrow and misaligned writes raise no write enable and are dropped
   assign we_select  = wr_commit && hit_select;
   assign we_level   = wr_commit && hit_level;
   assign we_enable  = wr_commit && hit_enable;
   assign we_ctrl    = wr_commit && hit_ctrl;

   // -------------------------------------------------------------------
   // configuration registers
   // -------------------------------------------------------------------

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         select_reg <= `SWCFG_SELECT_RST;
      end else if (we_select) begin
         // only bits 9..0 have storage, upper bits are dropped
         select_reg <= hwdata[`SWCFG_DIR_W-1:0];
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         level_reg <= `SWCFG_LEVEL_RST;
      end else if (we_level) begin
         // codes 5..7 are stored as written; only the decoder folds them
         level_reg <= hwdata[`SWCFG_REG_W-1:0];
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         enable_reg <= `SWCFG_ENABLE_RST;
      end else if (we_enable) begin
         // a disabled channel keeps its code and direction; its current and its polled bit are gated
         enable_reg <= hwdata[CHAN_N-1:0];
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ctrl_reg <= `SWCFG_CTRL_RST;
      end else if (we_ctrl) begin
         // each autoscale disable covers one group, picked by a channel's direction bit
         ctrl_reg <= hwdata[`SWCFG_CTRL_W-1:0];
      end
   end

   // -------------------------------------------------------------------
   // switch closure synchroniser
   // -------------------------------------------------------------------

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         closed_meta_reg <= '0;
         closed_sync_reg <= '0;
      end else begin
         // the pins are asynchronous to clock; only the second flop is read
         closed_meta_reg <= switch_closed;
         closed_sync_reg <= closed_meta_reg;
      end
   end

   // -------------------------------------------------------------------
   // per-channel decode
   // -------------------------------------------------------------------

   for (genvar c = 0; c < CHAN_N; c++) begin : g_chan
      // field index of this channel; pairs share one field
      localparam int FIELD = (c < 2)  ? 0 :
                             (c < 4)  ? 1 :
                             (c == 4) ? 2 :
                             (c == 5) ? 3 :
                             (c < 8)  ? 4 :
                             (c < 10) ? 5 :
                             (c == 10) ? 6 : 7;

      swcfg_chan_if u_if ();

      assign u_if.code       = level_reg[3*FIELD +: 3];
      assign u_if.closed     = closed_sync_reg[c];
      assign u_if.enabled    = enable_reg[c];
      assign u_if.continuous = ctrl_reg[`SWCFG_CTRL_CONT_BIT];
      assign u_if.dis_source = ctrl_reg[`SWCFG_CTRL_DIS_SRC];
      assign u_if.dis_sink   = ctrl_reg[`SWCFG_CTRL_DIS_SNK];

      if (c < `SWCFG_DIR_W) begin : g_dir
         assign u_if.sink = select_reg[c];
      end else begin : g_fixed
         // channels without a direction bit always source
         assign u_if.sink = 1'b0;
      end

      swcfg_level_decode u_dec (
         .port (u_if.dec)
      );

      assign sink_comb[c]         = u_if.sink;
      assign level_comb[3*c +: 3] = u_if.level;
      assign polled_comb[c]       = u_if.polled;
   end

   // -------------------------------------------------------------------
   // registered outputs
   // -------------------------------------------------------------------

   // one cycle of latency keeps the pins glitch-free on config writes
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         chan_sink <= '0;
      end else begin
         chan_sink <= sink_comb;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         chan_level <= '0;
      end else begin
         chan_level <= level_comb;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         chan_polled <= '0;
      end else begin
         chan_polled <= polled_comb;
      end
   end

endmodule // swcfg_regs

`default_nettype wire

// [test/swcfg_regs_chk.sv]
// assertion checker for the switch current config bank
`timescale 1ns/1ps
`include "swcfg_map.svh"
`default_nettype none
module swcfg_regs_chk #(
   parameter int CHAN_N = 12
) (
   // clock and reset
   input wire logic                clock,
   input wire logic                rst,
   // bus
   input wire logic                hsel,
   input wire logic [31:0]         haddr,
   input wire logic [1:0]          htrans,
   input wire logic                hwrite,
   input wire logic [2:0]          hsize,
   input wire logic                hready,
   input wire logic [31:0]         hwdata,
   input wire logic                hreadyout,
   input wire logic [31:0]         hrdata,
   input wire logic                hresp,
   // channels
   input wire logic [CHAN_N-1:0]   switch_closed,
   input wire logic [CHAN_N-1:0]   chan_sink,
   input wire logic [3*CHAN_N-1:0] chan_level,
   input wire logic [CHAN_N-1:0]   chan_polled
);
   wire logic tk = hsel && hready && htrans[1];
   wire logic sel_a = haddr[11:0] == {2'b00, `SWCFG_SELECT_IDX, 2'b00};
   function automatic logic [3*CHAN_N-1:0] spread(input logic [CHAN_N-1:0] m);
      for (int c = 0; c < CHAN_N; c++) spread[3*c +: 3] = {3{m[c]}};
   endfunction
   function automatic logic codes_ok(input logic [3*CHAN_N-1:0] v);
      codes_ok = 1'b1;
      for (int c = 0; c < CHAN_N; c++) if (v[3*c +: 3] > 3'h5) codes_ok = 1'b0;
   endfunction
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   chk_reset_clear: assert property ($fell(rst) |-> chan_level == '0 && chan_sink == '0
      && chan_polled == '0 && hreadyout) else $error("outputs not clear after reset");
   chk_read_wait: assert property (tk && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
   chk_write_zero: assert property (tk && hwrite |=> hreadyout)
      else $error("write stalled");
   chk_sel_upper: assert property (tk && !hwrite && sel_a |-> ##2 hrdata[31:10] == 22'h0)
      else $error("select upper bits not zero");
   chk_sink_follow: assert property (tk && hwrite && sel_a && hsize == `SWCFG_HSIZE_WORD |=> ##2
      chan_sink[9:0] == $past(hwdata[9:0], 2)) else $error("sink bits do not follow write");
   chk_sink_high: assert property (chan_sink[CHAN_N-1:10] == '0)
      else $error("sink set on fixed channel");
   chk_code_range: assert property (codes_ok(chan_level))
      else $error("level code out of range");
   chk_skip_off: assert property ((chan_level & spread(~chan_polled & ~$past(chan_polled))) == '0)
      else $error("disabled channel has current");
   cov_sel_write: cover property (tk && hwrite && sel_a);
   cov_read: cover property (tk && !hwrite);
   cov_scaled: cover property (chan_level[2:0] == 3'h2 && chan_polled[0]);
endmodule // swcfg_regs_chk
bind swcfg_regs swcfg_regs_chk #(.CHAN_N(CHAN_N)) i_chk (.clock, .rst, .hsel, .haddr, .htrans,
   .hwrite, .hsize, .hready, .hwdata, .hreadyout, .hrdata, .hresp, .switch_closed, .chan_sink,
   .chan_level, .chan_polled);
`default_nettype wire

// [test/swcfg_regs_test.sv]
// self-checking bench for the switch current config bank
`timescale 1ns/1ps
`include "swcfg_map.svh"
`default_nettype none
module swcfg_regs_test;
   localparam logic [11:0] A_SEL = {2'b00, `SWCFG_SELECT_IDX, 2'b00};
   localparam logic [11:0] A_LVL = {2'b00, `SWCFG_LEVEL_IDX, 2'b00};
   logic clock, rst, hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, d;
   logic [1:0]  htrans;
   logic [2:0]  hsize, ctl_m;
   logic [11:0] sw, chan_sink, chan_polled, en_m;
   logic [35:0] chan_level;
   logic [9:0]  sel_m;
   logic [23:0] lvl_m, w;
   int miscompares = 0, compares = 0;
   assign hready = hreadyout;
   swcfg_regs i_dut (.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hreadyout(hreadyout),
      .hrdata(hrdata), .hresp(hresp), .switch_closed(sw), .chan_sink(chan_sink),
      .chan_level(chan_level), .chan_polled(chan_polled));
   initial begin
      clock = 0;
      forever #50 clock = ~clock;
   end
   task chk(input string n, input logic [35:0] e, input logic [35:0] g);
      compares++;
      if (g !== e) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   // hready is judged at the falling edge, half a cycle from the rising edge, where nothing is moving
   task hs;
      do @(negedge clock); while (hready !== 1'b1);
   endtask
   task xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
      @(posedge clock);
      hsel <= 1; htrans <= 2'h2; hwrite <= wr; haddr <= {20'h0, a};
      hs;
      @(posedge clock);
      htrans <= 2'h0; hwdata <= wd;
      hs;
      rd = hrdata;
      @(posedge clock);
   endtask
   function automatic logic [2:0] ev(int c);
      logic [2:0] k;
      logic snk;
      k = lvl_m[3*(c < 4 ? c/2 : c < 6 ? c-2 : c < 10 ? c/2+1 : c-4) +: 3];
      snk = c < 10 && sel_m[c];
      if (k > 3'h4) k = 3'h5;
      if (!en_m[c]) k = 3'h0;
      else if (ctl_m[0] && sw[c] && !(snk ? ctl_m[2] : ctl_m[1]) && k >= 3'h4) k = 3'h2;
      return k;
   endfunction
   task chk_outs;
      logic [35:0] e;
      repeat (4) @(negedge clock);
      for (int c = 0; c < 12; c++) e[3*c +: 3] = ev(c);
      chk("chan_level", e, chan_level);
      chk("chan_sink", {26'h0, sel_m}, {24'h0, chan_sink});
      chk("chan_polled", {24'h0, en_m}, {24'h0, chan_polled});
   endtask
   task t_reset;
      xfer(0, A_SEL, 0, d); chk("select", 0, d);
      xfer(0, A_LVL, 0, d); chk("level", 0, d);
      chk_outs;
   endtask
   task t_select;
      xfer(1, A_SEL, 32'hFFFFFFFF, d); sel_m = 10'h3FF;
      chk("hresp", 0, hresp);
      xfer(0, A_SEL, 0, d); chk("select", 32'h3FF, d);
      chk_outs;
      xfer(1, A_SEL, 32'hFFFFFEAA, d); sel_m = 10'h2AA;
      xfer(0, A_SEL, 0, d); chk("select", 32'h2AA, d);
      chk_outs;
      @(posedge clock);
      hsize <= 3'h1;
      xfer(1, A_SEL, 32'h00000155, d);
      hsize <= `SWCFG_HSIZE_WORD;
      xfer(0, A_SEL, 0, d); chk("select", 32'h2AA, d);
      chk_outs;
   endtask
   task t_levels;
      xfer(1, `SWCFG_ENABLE_ADDR, 32'hFFF, d); en_m = 12'hFFF;
      for (int k = 0; k < 8; k++) begin
         for (int f = 0; f < 8; f++) w[3*f +: 3] = 3'((f + k) % 8);
         xfer(1, A_LVL, {8'h0, w}, d); lvl_m = w;
         xfer(0, A_LVL, 0, d); chk("level", {8'h0, w}, d);
         chk_outs;
      end
      xfer(0, 12'h200, 0, d); chk("unmapped", 0, d);
   endtask
   task t_disable;
      xfer(1, `SWCFG_ENABLE_ADDR, 32'h0F0, d); en_m = 12'h0F0;
      chk_outs;
      xfer(1, `SWCFG_ENABLE_ADDR, 32'hFFF, d); en_m = 12'hFFF;
   endtask
   task t_scale;
      logic [2:0] cv [5];
      cv = '{3'h1, 3'h1, 3'h3, 3'h5, 3'h0};
      xfer(1, A_LVL, 32'h924924, d); lvl_m = 24'h924924;
      xfer(1, A_SEL, 32'h001, d); sel_m = 10'h001;
      for (int i = 0; i < 5; i++) begin
         if (i == 1) sw <= 12'hFFF;
         xfer(1, `SWCFG_CTRL_ADDR, {29'h0, cv[i]}, d); ctl_m = cv[i];
         chk_outs;
      end
      xfer(0, `SWCFG_STATUS_ADDR, 0, d); chk("status", 32'hFFF, d);
      xfer(1, A_LVL, 32'hB6DB6D, d); lvl_m = 24'hB6DB6D;
      xfer(1, `SWCFG_CTRL_ADDR, 32'h1, d); ctl_m = 3'h1;
      chk_outs;
   endtask
   task t_mid_reset;
      @(posedge clock);
      rst <= 1;
      repeat (2) @(posedge clock);
      rst <= 0;
      sel_m = 0; lvl_m = 0; en_m = 0; ctl_m = 0;
      t_reset;
   endtask
   task complete_run;
      if (miscompares == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clock);
      miscompares++;
      complete_run;
   end
   initial begin
      rst = 1; hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hsize = `SWCFG_HSIZE_WORD;
      hwdata = 0; sw = 0; sel_m = 0; lvl_m = 0; en_m = 0; ctl_m = 0;
      repeat (6) @(posedge clock);
      rst <= 0;
      t_reset;
      t_select;
      t_levels;
      t_disable;
      t_scale;
      t_mid_reset;
      complete_run;
   end
endmodule // swcfg_regs_test
`default_nettype wire
